// *** hdl/hdmrp_device.sv ***
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module hdmrp_device
  import hdmrp_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int DEPTH  = 256,
  parameter int STRAP_W = 4,
  parameter int HOST_MODE_BIT = 2
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Host port
  hdmrp_if.device                 port,
  // Straps and pin function
  input  wire logic [STRAP_W-1:0] strapPins,
  output logic                    hostPortActive,
  // Core write to the overlay register
  input  wire logic               coreOvlWrite,
  input  wire logic [15:0]        coreOvlData,
  output logic [15:0]             overlayCtrl,
  // Core access to memory
  input  wire logic               coreMemWrite,
  input  wire logic               coreMemPmem,
  input  wire logic [ADDR_W-1:0]  coreMemAddr,
  input  wire logic [23:0]        coreMemData
);
  initial if (DEPTH < 2 || DEPTH > (1 << ADDR_W) || HOST_MODE_BIT >= STRAP_W)
    $error("unsupported device parameters");
  localparam int IW = $clog2(DEPTH);
  ////////////////////////////////////////////////////////////////
  logic [15:0]       dataMem [DEPTH];
  logic [23:0]       progMem [DEPTH];
  logic [STRAP_W-1:0] strapState;
  hdmrp_strap #(.WIDTH(STRAP_W)) u_strap (
    .core_clk   (core_clk),
    .rst        (rst),
    .strapPins  (strapPins),
    .strapState (strapState)
  );
  assign hostPortActive = strapState[HOST_MODE_BIT];
  ////////////////////////////////////////////////////////////////
  hdmrp_dev_t        state_q, state_d;
  logic [15:0]       addr_q;      // Host latched address, bit 14 picks program space
  logic              half_q;      // Second half of a program word pending
  logic [15:0]       prev_q;      // Prefetched word shown at read start
  logic [15:0]       ovl_q;
  logic [1:0]        cnt_q;
  logic              ackN_q;
  logic [15:0]       busOut_q;
  logic              oeN_q;
  logic [23:0]       pmWord_q;
  logic              curHalf_q;   // Half flag frozen for the read in progress
  wire               sel      = !port.hostSelectN && hostPortActive;
  wire               rdStart  = sel && !port.hostReadStrobeN;
  wire               wrStart  = sel && !port.hostWriteStrobeN;
  wire               latchGo  = sel && port.hostLatchAddr;
  wire               isPm     = addr_q[14];
  wire [IW-1:0]      memIdx   = addr_q[IW-1:0];
  wire               sroMode  = ovl_q[SRO_BIT];
  // Hold length follows the half that this read serves, not the advanced flag
  wire               holdDone = cnt_q == 2'((curHalf_q ? HOLD_SECOND_CYC : HOLD_FIRST_CYC) - 1);
  wire               hostOvl  = wrStart && addr_q == OVERLAY_ADDR;
  // Next word: program words come out upper 16 then low 8 bits
  wire [15:0]        nextWord = !isPm ? dataMem[memIdx]
                              : (half_q ? {8'h00, pmWord_q[7:0]} : progMem[memIdx][23:8]);
  assign overlayCtrl = ovl_q;
  ////////////////////////////////////////////////////////////////
  // Read framing: ack up within one cycle, down a cycle after word placed
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HDMRP_IDLE:    if (rdStart) state_d = HDMRP_FETCH;
      HDMRP_FETCH:   if (sroMode && !rdStart) state_d = HDMRP_IDLE;
                     else if (!sroMode && holdDone) state_d = HDMRP_SHOW;
      HDMRP_SHOW:    state_d = HDMRP_WAITEND;
      HDMRP_WAITEND: if (!rdStart) state_d = HDMRP_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q   <= HDMRP_IDLE;
      cnt_q     <= 2'd0;
      curHalf_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_q == HDMRP_FETCH) ? cnt_q + 2'd1 : 2'd0;
      if (state_q == HDMRP_IDLE && rdStart) curHalf_q <= half_q;
    end
  end
  // Ack: low when idle and ready, high from read start to word shown
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) ackN_q <= 1'b0;
    // Stays high through SHOW so the new word leads ack low by a cycle
    else     ackN_q <= (state_d == HDMRP_FETCH) || (state_d == HDMRP_SHOW) ||
                       (sroMode && state_q == HDMRP_FETCH && !rdStart);
  end
  // Bus drive: previous word first, new word before ack falls on long reads
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busOut_q <= 16'h0000;
      oeN_q    <= 1'b1;
    end else begin
      if (state_q == HDMRP_IDLE && rdStart) begin
        busOut_q <= prev_q;
        oeN_q    <= 1'b0;
      end else if (state_q == HDMRP_FETCH && holdDone && !sroMode) begin
        busOut_q <= prev_q;
      end
      if (!rdStart) oeN_q <= 1'b1;
    end
  end
  assign port.devBusOut = busOut_q;
  assign port.devBusOeN = oeN_q;
  assign port.hostAckN  = ackN_q;
  ////////////////////////////////////////////////////////////////
  // Address latch, prefetch and half sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_q   <= 16'h0000;
      half_q   <= 1'b0;
      prev_q   <= 16'h0000;
      pmWord_q <= 24'h000000;
    end else if (latchGo) begin
      addr_q <= port.busLevel;
      half_q <= 1'b0;
    end else if (state_q == HDMRP_IDLE && rdStart) begin
      prev_q <= nextWord;
      if (!isPm) begin
        addr_q <= addr_q + 16'd1;
      end else if (!half_q) begin
        pmWord_q <= progMem[memIdx];
        half_q   <= 1'b1;
      end else begin
        half_q <= 1'b0;
        addr_q <= addr_q + 16'd1;
      end
    end
  end
  // Overlay: core or host may write, reset clears mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)           ovl_q <= OVERLAY_RESET;
    else if (hostOvl)  ovl_q <= port.busLevel;
    else if (coreOvlWrite) ovl_q <= coreOvlData;
  end
  // Memory: core writes both spaces, host has no write path
  always_ff @(posedge core_clk) begin
    if (coreMemWrite && coreMemPmem)  progMem[coreMemAddr[IW-1:0]] <= coreMemData;
    if (coreMemWrite && !coreMemPmem) dataMem[coreMemAddr[IW-1:0]] <= coreMemData[15:0];
  end
endmodule

// *** hdl/hdmrp_pkg.sv ***
// How it works
// - Host waits for ack low before reading.
// - Device raises ack quickly, holds until ready.
// - Long read: data on bus before ack low.
// - Read start drives previously prefetched word.
// - Previous word held two or one clocks.
// - Data word one read; program word two.
// - Short read pulse bounded by one/two clocks.
// - Read end releases bus within bound.
// - Overlay bit 14 enables short-read-only mode.
// - Reset clears short-read-only enable bit.
// - Core and host may both write enable.
// - Short-read-only holds previous word until end.
// - Prefer short-read-only at high clock rates.
// - Strap pins latched at reset release.
// - Strap two selects host-port pin functions.
package hdmrp_pkg;
  localparam int           CLK_PERIOD_NS    = 10;
  localparam int           ACK_RISE_MAX_NS  = 10;
  localparam int           ACK_RISE_CYC     = (ACK_RISE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                              ACK_RISE_MAX_NS / CLK_PERIOD_NS;
  localparam int           MIN_PULSE_NS     = 10;
  localparam int           MIN_PULSE_CYC    = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int           HOLD_FIRST_CYC   = 2;
  localparam int           HOLD_SECOND_CYC  = 1;
  localparam int           MEM_LATENCY_CYC  = 3;
  localparam logic [15:0]  OVERLAY_ADDR     = 16'h3FE7;
  localparam int           SRO_BIT          = 14;
  localparam logic [15:0]  OVERLAY_RESET    = 16'h0000;
  localparam logic [15:0]  SPACE_BIT_MASK   = 16'h4000;
  // Controller register offsets (APB byte addresses)
  localparam logic [7:0]   REG_CTRL         = 8'h00;
  localparam logic [7:0]   REG_ADDR         = 8'h04;
  localparam logic [7:0]   REG_DATA         = 8'h08;
  localparam logic [7:0]   REG_STAT         = 8'h0C;
  localparam int           CTRL_GO_BIT      = 0;
  localparam int           CTRL_SRO_BIT     = 1;
  localparam int           CTRL_PMEM_BIT    = 2;
  localparam int           CTRL_WSRO_BIT    = 3;
  localparam int           STAT_BUSY_BIT    = 0;
  localparam int           STAT_DONE_BIT    = 1;
  typedef enum logic [2:0] {
    HDMRP_IDLE = 3'b000,
    HDMRP_FETCH = 3'b001,
    HDMRP_SHOW = 3'b011,
    HDMRP_WAITEND = 3'b010
  } hdmrp_dev_t;
  typedef enum logic [2:0] {
    HDMRC_IDLE = 3'b000,
    HDMRC_WAITACK = 3'b001,
    HDMRC_STROBE = 3'b011,
    HDMRC_GAP = 3'b010
  } hdmrp_host_t;
endpackage

// *** hdl/hdmrp_if.sv ***
`timescale 1ns/10ps
interface hdmrp_if;
  logic        hostSelectN;
  logic        hostReadStrobeN;
  logic        hostWriteStrobeN;
  logic        hostLatchAddr;
  logic [15:0] hostBusOut;
  logic        hostBusOeN;
  logic [15:0] devBusOut;
  logic        devBusOeN;
  logic        hostAckN;
  logic [15:0] busLevel;
  // Wire resolution: whoever enables drives, else pulled high
  assign busLevel = !devBusOeN ? devBusOut : (!hostBusOeN ? hostBusOut : 16'hFFFF);
  modport device (input hostSelectN, hostReadStrobeN, hostWriteStrobeN, hostLatchAddr, busLevel,
                  output devBusOut, devBusOeN, hostAckN);
  modport host (output hostSelectN, hostReadStrobeN, hostWriteStrobeN, hostLatchAddr, hostBusOut,
                hostBusOeN, input hostAckN, busLevel);
endinterface

// *** hdl/hdmrp_strap.sv ***
`timescale 1ns/10ps
module hdmrp_strap
  import hdmrp_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Strap pins and latched state
  input  wire logic [WIDTH-1:0] strapPins,
  output logic      [WIDTH-1:0] strapState
);
  initial if (WIDTH < 1) $error("strap width must be positive");
  logic [WIDTH-1:0] state_q;
  logic             taken_q;
  // Catch straps on the first edge after release, never under reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      taken_q <= 1'b0;
      state_q <= '0;
    end else if (!taken_q) begin
      taken_q <= 1'b1;
      state_q <= strapPins;
    end
  end
  assign strapState = state_q;
endmodule

// *** hdl/hdmrp_host.sv ***
`timescale 1ns/10ps
module hdmrp_host
  import hdmrp_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Host port
  hdmrp_if.host            port
);
  hdmrp_host_t st_q;
  logic [15:0] ctrl_q, addr_q, data_q;
  logic        done_q, lat_q;
  logic [2:0]  cnt_q;
  wire         wr    = psel && penable && pwrite;
  wire         goCmd = wr && paddr == REG_CTRL && pwdata[CTRL_GO_BIT];
  wire         known = paddr == REG_CTRL || paddr == REG_ADDR || paddr == REG_DATA || paddr == REG_STAT;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata  = paddr == REG_CTRL ? {16'h0000, ctrl_q} : paddr == REG_ADDR ? {16'h0000, addr_q}
                 : paddr == REG_DATA ? {16'h0000, data_q}
                 : paddr == REG_STAT ? {30'h0, done_q, st_q != HDMRC_IDLE} : 32'h0;
  ////////////////////////////////////////////////////////////////
  // Registers and read sequence: latch address, wait ack, strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 16'h0000;
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
      done_q <= 1'b0;
      lat_q  <= 1'b0;
      cnt_q  <= 3'd0;
      st_q   <= HDMRC_IDLE;
    end else begin
      if (wr && paddr == REG_CTRL) ctrl_q <= pwdata[15:0];
      if (wr && paddr == REG_ADDR) begin
        addr_q <= pwdata[15:0];
        lat_q  <= 1'b1;
      end else lat_q <= 1'b0;
      if (goCmd) done_q <= 1'b0;
      unique case (st_q)
        HDMRC_IDLE:    if (goCmd) st_q <= HDMRC_WAITACK;
        HDMRC_WAITACK: if (!port.hostAckN) begin
                         st_q  <= HDMRC_STROBE;
                         cnt_q <= 3'd0;
                       end
        HDMRC_STROBE:  begin
                         cnt_q <= cnt_q + 3'd1;
                         // Short read ends after min pulse, long read waits for ack low
                         if (ctrl_q[CTRL_SRO_BIT] ? cnt_q >= 3'(MIN_PULSE_CYC)
                             : (cnt_q > 3'd1 && !port.hostAckN)) begin
                           data_q <= port.busLevel;
                           st_q   <= HDMRC_GAP;
                         end
                       end
        HDMRC_GAP:     begin
                         done_q <= 1'b1;
                         st_q   <= HDMRC_IDLE;
                       end
      endcase
    end
  end
  // Pins: address latch pulse, read strobe; host never drives during read
  assign port.hostSelectN      = !(lat_q || st_q == HDMRC_STROBE);
  assign port.hostReadStrobeN  = st_q != HDMRC_STROBE;
  assign port.hostWriteStrobeN = 1'b1;
  assign port.hostLatchAddr    = lat_q;
  assign port.hostBusOut       = addr_q;
  assign port.hostBusOeN       = !lat_q;
endmodule

// *** testbench/hdmrp_monitor.sv ***
`timescale 1ns/10ps
module hdmrp_monitor (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Host port wires
  input wire logic        hostSelectN,
  input wire logic        hostReadStrobeN,
  input wire logic [15:0] devBusOut,
  input wire logic        devBusOeN,
  input wire logic        hostAckN
);
  logic rdOn;
  // Read is on while select and strobe are both low
  assign rdOn = !hostSelectN && !hostReadStrobeN;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  //////////////////////////////
  property p_ackRise; $rose(rdOn) |=> hostAckN; endproperty
  a_ackRise: assert property (p_ackRise) else $error("ack late");
  property p_ackCause; $rose(hostAckN) |-> $past(rdOn); endproperty
  a_ackCause: assert property (p_ackCause) else $error("ack rose alone");
  // Bound is loose: short-read-only ack waits for the host
  property p_ackBound; $rose(hostAckN) |-> ##[1:20] !hostAckN; endproperty
  a_ackBound: assert property (p_ackBound) else $error("ack stuck");
  property p_prevDrive; $rose(rdOn) |=> !devBusOeN; endproperty
  a_prevDrive: assert property (p_prevDrive) else $error("no prev word");
  property p_hold; $rose(rdOn) |-> ##2 (!rdOn || !devBusOeN); endproperty
  a_hold: assert property (p_hold) else $error("prev word dropped");
  property p_dataFirst; $fell(hostAckN) && rdOn |-> !$past(devBusOeN) && $stable(devBusOut); endproperty
  a_dataFirst: assert property (p_dataFirst) else $error("data after ack");
  property p_release; $fell(rdOn) |=> devBusOeN; endproperty
  a_release: assert property (p_release) else $error("bus kept");
  property p_idleOff; !rdOn && !$past(rdOn) |-> devBusOeN; endproperty
  a_idleOff: assert property (p_idleOff) else $error("bus driven idle");
endmodule

// *** testbench/hdmrp_bench.sv ***
`timescale 1ns/10ps
module hdmrp_bench
  import hdmrp_pkg::*;
;
  logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, hostPortActive;
  logic        coreOvlWrite = 1'b0, coreMemWrite = 1'b0, coreMemPmem = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] coreOvlData = 16'h0, overlayCtrl, d;
  logic [13:0] coreMemAddr = 14'h0;
  logic [23:0] coreMemData = 24'h0;
  logic [23:0] dmMem [256];
  logic [23:0] pmMem [256];
  logic [7:0]  a;
  logic        e;
  int          err_count = 0, num_checks = 0;
  hdmrp_if     port ();
  //////////////////////////////
  hdmrp_device hdmrp_device_inst (.core_clk, .rst, .port(port.device), .strapPins(4'h4), .hostPortActive,
    .coreOvlWrite, .coreOvlData, .overlayCtrl, .coreMemWrite, .coreMemPmem, .coreMemAddr, .coreMemData);
  hdmrp_host hdmrp_host_inst (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port(port.host));
  hdmrp_monitor hdmrp_monitor_inst (.core_clk, .rst, .hostSelectN(port.hostSelectN),
    .hostReadStrobeN(port.hostReadStrobeN), .devBusOut(port.devBusOut), .devBusOeN(port.devBusOeN),
    .hostAckN(port.hostAckN));
  // Free-running core clock
  always #5 core_clk = ~core_clk;
  //////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Program word comes as high 16 bits, then low byte
  function automatic logic [15:0] expWord(logic pm, logic half2, logic [23:0] w);
    return pm ? (half2 ? {8'h00, w[7:0]} : w[23:8]) : w[15:0];
  endfunction
  // One APB transfer; answer taken at the rising edge that sees pready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    logic ok;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      ok = pready;
      r = prdata;
      e = pslverr;
    end while (ok !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic memWr(input logic pm, input logic [7:0] ad, input logic [23:0] wd);
    coreMemWrite <= 1'b1;
    coreMemPmem <= pm;
    coreMemAddr <= {6'h00, ad};
    coreMemData <= wd;
    @(posedge core_clk);
    coreMemWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic ovlWr(input logic [15:0] v);
    coreOvlWrite <= 1'b1;
    coreOvlData <= v;
    @(posedge core_clk);
    coreOvlWrite <= 1'b0;
    @(negedge core_clk);
    chk({16'h0, overlayCtrl}, {16'h0, v});
    @(posedge core_clk);
  endtask
  // Start one host read, wait for completion, fetch the word
  task automatic hostRead(input logic [3:0] ctl);
    int n;
    apb(1'b1, REG_CTRL, {28'h0, ctl});
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (!(r[STAT_BUSY_BIT] === 1'b0 && r[STAT_DONE_BIT] === 1'b1) && n < 40);
    if (n >= 40) err_count++;
    apb(1'b0, REG_DATA, 32'h0);
    d = r[15:0];
  endtask
  //////////////////////////////
  initial begin
    void'($urandom(2101));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk({31'h0, hostPortActive}, 32'h1);
    chk({16'h0, overlayCtrl}, {16'h0, OVERLAY_RESET});
    @(posedge core_clk);
    $display("test reset done");
    ovlWr(16'($urandom));
    ovlWr(16'h4000);
    ovlWr(16'h0000);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("test overlay and refusal done");
    // Corner address zero first, then random places
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 8'h00 : 8'($urandom_range(1, 254));
      dmMem[a] = 24'($urandom);
      pmMem[a] = 24'($urandom);
      memWr(1'b0, a, dmMem[a]);
      memWr(1'b1, a, pmMem[a]);
      apb(1'b1, REG_ADDR, {24'h0, a});
      hostRead(4'h1);
      chk({16'h0, d}, {16'h0, expWord(1'b0, 1'b0, dmMem[a])});
      apb(1'b1, REG_ADDR, {16'h0, SPACE_BIT_MASK | {8'h00, a}});
      hostRead(4'h5);
      chk({16'h0, d}, {16'h0, expWord(1'b1, 1'b0, pmMem[a])});
      hostRead(4'h5);
      chk({16'h0, d}, {16'h0, expWord(1'b1, 1'b1, pmMem[a])});
    end
    $display("test long reads done");
    ovlWr(16'h4000);
    apb(1'b1, REG_ADDR, {24'h0, a});
    hostRead(4'h3);
    hostRead(4'h3);
    chk({16'h0, d}, {16'h0, expWord(1'b0, 1'b0, dmMem[a])});
    ovlWr(16'h0000);
    $display("test short read only done");
    complete_run();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    complete_run();
  end
endmodule
